// ==== core/drb_clamp.v ====
// Purpose: saturate a signed analog output setting to the accepted range
// Assumes: two's complement 16-bit counts
// Notes:   purely combinational
`include "drb_regs.vh"

module drb_clamp (
   input  wire signed [15:0] d_i,
   output reg  signed [15:0] q_o
);

   // saturate rather than wrap so a bad write cannot flip polarity
   always @* begin
      if (d_i > `DRB_ANALOG_MAX) begin
         q_o = `DRB_ANALOG_MAX;
      end else if (d_i < `DRB_ANALOG_MIN) begin
         q_o = `DRB_ANALOG_MIN;
      end else begin
         q_o = d_i;
      end
   end

endmodule // drb_clamp

// ==== core/drb_mask_reg.v ====
// Purpose: one 16-bit bank register with a writable-bit mask
// Assumes: synchronous active-low reset, write strobe on the bank clock
// Notes:   bits outside the mask never store and read back as zero
module drb_mask_reg #(
   parameter [15:0] MASK  = 16'hffff,
   parameter [15:0] RESET = 16'h0000
) (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        we_i,
   input  wire [15:0] d_i,
   output reg  [15:0] q_o
);

   // masking here keeps a careless master from setting unused bits
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         q_o <= RESET & MASK;
      end else if (we_i) begin
         q_o <= d_i & MASK;
      end
   end

endmodule // drb_mask_reg

// ==== core/drb_top.v ====
// Purpose: writable reference register bank of a motor drive, behind the
//          serial link's function handler
// Assumes: the handler presents one decoded register access per strobe on
//          the bank clock; drive-side inputs come from logic on the same
//          clock, except the local terminal levels, which are pins
// Notes:   reads answer one cycle after the strobe; every output is a flop;
//          side outputs follow a write two edges later (register, then flop), fault reset one edge;
//          local terminal levels lag their pins by two more edges
`include "drb_regs.vh"

module drb_top (
   input  wire        clk_i,
   input  wire        rst_n_i,
   // register access from the function handler
   input  wire        wr_en_i,
   input  wire        rd_en_i,
   input  wire [15:0] addr_i,
   input  wire [15:0] wr_data_i,
   output reg  [15:0] rd_data_o,
   output reg         rd_valid_o,
   output reg         wr_ignored_o,
   // drive-side inputs
   input  wire [1:0]  display_unit_param_i,
   input  wire        drive_fault_relay_i,
   input  wire        local_terminal_five_i,
   input  wire        local_terminal_six_i,
   input  wire        local_terminal_seven_i,
   input  wire        bcast_terminal_five_i,
   input  wire        bcast_terminal_six_i,
   input  wire        bcast_terminal_seven_i,
   // sequence commands
   output reg         run_forward_o,
   output reg         run_reverse_o,
   output reg         bus_external_fault_o,
   output reg         fault_reset_o,
   output reg         network_select_bit_o,
   output reg         remote_control_bit_o,
   output reg  [4:0]  mf_input_cmd_o,
   // references
   output reg  [15:0] frequency_ref_o,
   output reg  [1:0]  frequency_units_o,
   output reg  [15:0] process_setpoint_o,
   output reg         process_setpoint_en_o,
   output reg  [15:0] analog_out_one_o,
   output reg  [15:0] analog_out_two_o,
   // contact outputs and terminals
   output reg         digital_out_one_terminal_o,
   output reg         digital_out_two_terminal_o,
   output reg         fault_relay_terminal_o,
   output reg         input_terminal_five_o,
   output reg         input_terminal_six_o,
   output reg         input_terminal_seven_o
);

   wire [15:0] seq_q;
   wire [15:0] freq_q;
   wire [15:0] setp_q;
   wire [15:0] aout1_q;
   wire [15:0] aout2_q;
   wire [15:0] con_q;
   wire [15:0] sel_q;
   wire [15:0] aout1_sat;
   wire [15:0] aout2_sat;

   // local terminals are pins: two flops before anything reads them, so a
   // level caught mid-change never reaches the terminal mux unsettled
   reg  [2:0]  local_meta_reg;
   reg  [2:0]  local_sync_reg;
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         local_meta_reg <= 3'h0;
         local_sync_reg <= 3'h0;
      end else begin
         local_meta_reg <= {local_terminal_seven_i, local_terminal_six_i,
                            local_terminal_five_i};
         local_sync_reg <= local_meta_reg;
      end
   end

   // address decode of writes; unmapped and reserved slots are dropped
   wire we_seq   = wr_en_i && (addr_i == `DRB_REG_SEQUENCE_CMD);
   wire we_freq  = wr_en_i && (addr_i == `DRB_REG_FREQUENCY_REF);
   wire we_setp  = wr_en_i && (addr_i == `DRB_REG_PROCESS_SETPOINT);
   wire we_aout1 = wr_en_i && (addr_i == `DRB_REG_ANALOG_OUT_ONE);
   wire we_aout2 = wr_en_i && (addr_i == `DRB_REG_ANALOG_OUT_TWO);
   wire we_con   = wr_en_i && (addr_i == `DRB_REG_CONTACT_OVERRIDE);
   wire we_sel   = wr_en_i && (addr_i == `DRB_REG_REF_SOURCE_SEL);
   wire we_any   = we_seq | we_freq | we_setp | we_aout1 | we_aout2 | we_con | we_sel;

   // storage; masks drop unused bits in case a master ignores the zero-fill
   drb_mask_reg #(.MASK(`DRB_SEQ_MASK), .RESET(`DRB_RESET_VALUE)) u_seq (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .we_i    (we_seq),
      .d_i     (wr_data_i),
      .q_o     (seq_q)
   );

   drb_mask_reg #(.MASK(`DRB_FULL_MASK), .RESET(`DRB_RESET_VALUE)) u_freq (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .we_i    (we_freq),
      .d_i     (wr_data_i),
      .q_o     (freq_q)
   );

   drb_mask_reg #(.MASK(`DRB_FULL_MASK), .RESET(`DRB_RESET_VALUE)) u_setp (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .we_i    (we_setp),
      .d_i     (wr_data_i),
      .q_o     (setp_q)
   );

   // analog settings saturate before storage so readback shows what is driven
   drb_clamp u_clamp1 (
      .d_i (wr_data_i),
      .q_o (aout1_sat)
   );

   drb_clamp u_clamp2 (
      .d_i (wr_data_i),
      .q_o (aout2_sat)
   );

   drb_mask_reg #(.MASK(`DRB_FULL_MASK), .RESET(`DRB_RESET_VALUE)) u_aout1 (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .we_i    (we_aout1),
      .d_i     (aout1_sat),
      .q_o     (aout1_q)
   );

   drb_mask_reg #(.MASK(`DRB_FULL_MASK), .RESET(`DRB_RESET_VALUE)) u_aout2 (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .we_i    (we_aout2),
      .d_i     (aout2_sat),
      .q_o     (aout2_q)
   );

   drb_mask_reg #(.MASK(`DRB_CON_MASK), .RESET(`DRB_RESET_VALUE)) u_con (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .we_i    (we_con),
      .d_i     (wr_data_i),
      .q_o     (con_q)
   );

   drb_mask_reg #(.MASK(`DRB_SEL_MASK), .RESET(`DRB_RESET_VALUE)) u_sel (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .we_i    (we_sel),
      .d_i     (wr_data_i),
      .q_o     (sel_q)
   );

   // read mux; reserved, not-used and unmapped registers read zero
   reg [15:0] rd_data_next;
   always @* begin
      case (addr_i)
         `DRB_REG_SEQUENCE_CMD:     rd_data_next = seq_q;
         `DRB_REG_FREQUENCY_REF:    rd_data_next = freq_q;
         `DRB_REG_PROCESS_SETPOINT: rd_data_next = setp_q;
         `DRB_REG_ANALOG_OUT_ONE:   rd_data_next = aout1_q;
         `DRB_REG_ANALOG_OUT_TWO:   rd_data_next = aout2_q;
         `DRB_REG_CONTACT_OVERRIDE: rd_data_next = con_q;
         `DRB_REG_REF_SOURCE_SEL:   rd_data_next = sel_q;
         default:                   rd_data_next = `DRB_RESET_VALUE;
      endcase
   end

   // read answer one cycle after the strobe; data holds until the next read
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         rd_data_o  <= `DRB_RESET_VALUE;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= rd_en_i;
         if (rd_en_i) begin
            rd_data_o <= rd_data_next;
         end
      end
   end

   // dropped-write flag; a pulse, so the handler can answer with an error
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ignored_o <= 1'b0;
      end else begin
         wr_ignored_o <= wr_en_i && !we_any;
      end
   end

   // sequence command levels follow the stored register
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         run_forward_o        <= 1'b0;
         run_reverse_o        <= 1'b0;
         bus_external_fault_o <= 1'b0;
         network_select_bit_o <= 1'b0;
         remote_control_bit_o <= 1'b0;
         mf_input_cmd_o       <= 5'h00;
      end else begin
         run_forward_o        <= seq_q[`DRB_SEQ_RUN_FWD];
         run_reverse_o        <= seq_q[`DRB_SEQ_RUN_REV];
         bus_external_fault_o <= seq_q[`DRB_SEQ_EXT_FAULT];
         network_select_bit_o <= seq_q[`DRB_SEQ_NET_SEL];
         remote_control_bit_o <= seq_q[`DRB_SEQ_REMOTE_CTRL];
         mf_input_cmd_o       <= seq_q[`DRB_SEQ_MF_MSB:`DRB_SEQ_MF_LSB];
      end
   end

   // fault reset is one pulse per write with bit 3 set, not a level, so a
   // stored bit cannot hold the drive in reset
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         fault_reset_o <= 1'b0;
      end else begin
         fault_reset_o <= we_seq && wr_data_i[`DRB_SEQ_FAULT_RESET];
      end
   end

   // frequency and setpoint; units follow the display parameter, not the bank
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         frequency_ref_o       <= `DRB_RESET_VALUE;
         frequency_units_o     <= 2'h0;
         process_setpoint_o    <= `DRB_RESET_VALUE;
         process_setpoint_en_o <= 1'b0;
      end else begin
         frequency_ref_o       <= freq_q;
         frequency_units_o     <= display_unit_param_i;
         process_setpoint_o    <= setp_q;
         process_setpoint_en_o <= sel_q[`DRB_SEL_SETPOINT_EN];
      end
   end

   // analog outputs; storage already holds the saturated counts
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         analog_out_one_o <= `DRB_RESET_VALUE;
         analog_out_two_o <= `DRB_RESET_VALUE;
      end else begin
         analog_out_one_o <= aout1_q;
         analog_out_two_o <= aout2_q;
      end
   end

   // digital contact outputs follow their override bits
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         digital_out_one_terminal_o <= 1'b0;
         digital_out_two_terminal_o <= 1'b0;
      end else begin
         digital_out_one_terminal_o <= con_q[`DRB_CON_DOUT_ONE];
         digital_out_two_terminal_o <= con_q[`DRB_CON_DOUT_TWO];
      end
   end

   // relay stays with the drive unless the bus takes it; a stale level bit
   // has no effect until the grant bit is set
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         fault_relay_terminal_o <= 1'b0;
      end else begin
         if (con_q[`DRB_CON_RELAY_GRANT]) begin
            fault_relay_terminal_o <= con_q[`DRB_CON_RELAY_LEVEL];
         end else begin
            fault_relay_terminal_o <= drive_fault_relay_i;
         end
      end
   end

   // terminal sources; broadcast data replaces the local level when enabled
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         input_terminal_five_o  <= 1'b0;
         input_terminal_six_o   <= 1'b0;
         input_terminal_seven_o <= 1'b0;
      end else begin
         input_terminal_five_o  <= sel_q[`DRB_SEL_TERM_FIVE_EN] ?
                                   bcast_terminal_five_i : local_sync_reg[0];
         input_terminal_six_o   <= sel_q[`DRB_SEL_TERM_SIX_EN] ?
                                   bcast_terminal_six_i : local_sync_reg[1];
         input_terminal_seven_o <= sel_q[`DRB_SEL_TERM_SEVEN_EN] ?
                                   bcast_terminal_seven_i : local_sync_reg[2];
      end
   end

endmodule // drb_top

// ==== inc/drb_regs.vh ====
// Purpose: register numbers, field positions, masks and reset values of the
//          drive reference register bank
// Assumes: register numbers are 16-bit word indexes on the internal access port
// Notes:   definitions only
`ifndef DRB_REGS_VH
`define DRB_REGS_VH

// register numbers
`define DRB_REG_RESERVED_BASE    16'h0000
`define DRB_REG_SEQUENCE_CMD     16'h0001
`define DRB_REG_FREQUENCY_REF    16'h0002
`define DRB_REG_PROCESS_SETPOINT 16'h0006
`define DRB_REG_ANALOG_OUT_ONE   16'h0007
`define DRB_REG_ANALOG_OUT_TWO   16'h0008
`define DRB_REG_CONTACT_OVERRIDE 16'h0009
`define DRB_REG_REF_SOURCE_SEL   16'h000f

// sequence command fields
`define DRB_SEQ_RUN_FWD          0
`define DRB_SEQ_RUN_REV          1
`define DRB_SEQ_EXT_FAULT        2
`define DRB_SEQ_FAULT_RESET      3
`define DRB_SEQ_NET_SEL          4
`define DRB_SEQ_REMOTE_CTRL      5
`define DRB_SEQ_MF_LSB           6
`define DRB_SEQ_MF_MSB           10
`define DRB_SEQ_MASK             16'h07ff

// contact output override fields
`define DRB_CON_DOUT_ONE         0
`define DRB_CON_DOUT_TWO         1
`define DRB_CON_RELAY_GRANT      6
`define DRB_CON_RELAY_LEVEL      7
`define DRB_CON_MASK             16'h00c3

// reference source select fields
`define DRB_SEL_SETPOINT_EN      1
`define DRB_SEL_TERM_FIVE_EN     12
`define DRB_SEL_TERM_SIX_EN      13
`define DRB_SEL_TERM_SEVEN_EN    14
`define DRB_SEL_MASK             16'h7002

// full-width registers
`define DRB_FULL_MASK            16'hffff

// analog output limits in counts (+-11 V), 660 counts is 10 V
`define DRB_ANALOG_MAX           16'sh02d6
`define DRB_ANALOG_MIN           -16'sh02d6
`define DRB_ANALOG_TEN_VOLT      16'h0294

// reset values
`define DRB_RESET_VALUE          16'h0000

`endif

// ==== testbench/drb_master.sv ====
// Purpose: bus master model issuing decoded register accesses
// Assumes: strobes change at the falling edge, one cycle per word
// Notes:   released lines show the inverse of their last value
module drb_master (
   input  wire         clk_i,
   input  wire  [15:0] rd_data_i,
   input  wire         rd_valid_i,
   output logic        wr_en_o,
   output logic        rd_en_o,
   output logic [15:0] addr_o,
   output logic [15:0] wr_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o = 16'h0000;
      wr_data_o = 16'h0000;
   end
   // callers may set unused bits; reserved places only in refusal tests
   task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk_i);
      addr_o = a;
      wr_data_o = d;
      wr_en_o = 1'b1;
      @(negedge clk_i);
      wr_en_o = 1'b0;
      addr_o = ~a;
      wr_data_o = ~d;
   endtask
   // two words back to back, high word first, ascending registers; the strobe
   // stays up between them, never lowered and raised in one time step
   task automatic write_pair(input logic [15:0] a, input logic [31:0] d);
      @(negedge clk_i);
      addr_o = a;
      wr_data_o = d[31:16];
      wr_en_o = 1'b1;
      @(negedge clk_i);
      addr_o = a + 16'h0001;
      wr_data_o = d[15:0];
      @(negedge clk_i);
      wr_en_o = 1'b0;
      addr_o = ~(a + 16'h0001);
      wr_data_o = ~d[15:0];
   endtask
   // answer is settled half a cycle after the taking edge
   task automatic read_reg(input logic [15:0] a, output logic [15:0] d, output logic v);
      @(negedge clk_i);
      addr_o = a;
      rd_en_o = 1'b1;
      @(negedge clk_i);
      rd_en_o = 1'b0;
      addr_o = ~a;
      d = rd_data_i;
      v = rd_valid_i;
   endtask
endmodule // drb_master

// ==== testbench/drb_props.sv ====
// Purpose: port assertions for the reference register bank
// Assumes: one clock, synchronous active-low reset
// Notes:   side outputs lag a write by two edges (register then output flop), fault reset by one
module drb_props (
   input wire        clk_i,
   input wire        rst_n_i,
   input wire        wr_en_i,
   input wire        rd_en_i,
   input wire [15:0] addr_i,
   input wire [15:0] wr_data_i,
   input wire [1:0]  display_unit_param_i,
   input wire        rd_valid_o,
   input wire        wr_ignored_o,
   input wire        fault_reset_o,
   input wire        run_forward_o,
   input wire        run_reverse_o,
   input wire        bus_external_fault_o,
   input wire [4:0]  mf_input_cmd_o,
   input wire [1:0]  frequency_units_o,
   input wire [15:0] analog_out_one_o,
   input wire        digital_out_one_terminal_o,
   input wire        fault_relay_terminal_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // write strobes decoded once, shared by several properties
   logic seq_wr;
   logic con_wr;
   assign seq_wr = wr_en_i && addr_i == 16'h0001;
   assign con_wr = wr_en_i && addr_i == 16'h0009;

   read_answer_a: assert property (rd_en_i |=> rd_valid_o)
      else $error("read not answered in the next cycle");
   valid_pulse_a: assert property (!rd_en_i |=> !rd_valid_o)
      else $error("read valid without a read");
   reset_pulse_a: assert property (seq_wr |=> fault_reset_o == $past(wr_data_i[3]))
      else $error("fault reset pulse wrong");
   run_fwd_a: assert property (seq_wr |=> ##1 run_forward_o == $past(wr_data_i[0], 2))
      else $error("forward run wrong");
   run_rev_a: assert property (seq_wr |=> ##1 run_reverse_o == $past(wr_data_i[1], 2))
      else $error("reverse run wrong");
   ext_fault_a: assert property (seq_wr |=> ##1 bus_external_fault_o == $past(wr_data_i[2], 2))
      else $error("external fault wrong");
   mf_cmd_a: assert property (seq_wr |=> ##1 mf_input_cmd_o == $past(wr_data_i[10:6], 2))
      else $error("input commands wrong");
   relay_grant_a: assert property (con_wr && wr_data_i[6]
      |=> ##1 fault_relay_terminal_o == $past(wr_data_i[7], 2))
      else $error("granted relay level wrong");
   dout_one_a: assert property (con_wr
      |=> ##1 digital_out_one_terminal_o == $past(wr_data_i[0], 2))
      else $error("digital output one wrong");
   clamp_high_a: assert property (wr_en_i && addr_i == 16'h0007 && $signed(wr_data_i) > 726
      |=> ##1 analog_out_one_o == 16'h02d6)
      else $error("analog output not limited");
   ignore_rsvd_a: assert property (wr_en_i && (addr_i == 16'h0000 || addr_i > 16'h000f)
      |=> wr_ignored_o)
      else $error("reserved write not flagged");
   unit_follow_a: assert property ($past(rst_n_i)
      |-> frequency_units_o == $past(display_unit_param_i))
      else $error("display units not followed");
endmodule // drb_props

bind drb_top drb_props drb_props_inst (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
   .wr_data_i(wr_data_i), .display_unit_param_i(display_unit_param_i),
   .rd_valid_o(rd_valid_o), .wr_ignored_o(wr_ignored_o), .fault_reset_o(fault_reset_o),
   .run_forward_o(run_forward_o), .run_reverse_o(run_reverse_o),
   .bus_external_fault_o(bus_external_fault_o), .mf_input_cmd_o(mf_input_cmd_o),
   .frequency_units_o(frequency_units_o), .analog_out_one_o(analog_out_one_o),
   .digital_out_one_terminal_o(digital_out_one_terminal_o),
   .fault_relay_terminal_o(fault_relay_terminal_o)
);

// ==== testbench/tb_drb_top.sv ====
// Purpose: self-checking bench for the reference register bank
// Assumes: master model drives accesses at the falling edge
// Notes:   expected values come from the register map, not the design
module tb_drb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, rst_n_i, relay_in, vld;
   logic [1:0]  unit_param;
   logic [2:0]  loc_in, bc_in;
   logic [15:0] got;
   wire         wr_en, rd_en, rd_valid, wr_ign, fwd, rev, efault, frst, nsel, rctl;
   wire         sp_en, d1, d2, relay, t5, t6, t7;
   wire  [15:0] addr, wr_data, rd_data, ao1, ao2, freq, setp;
   wire  [4:0]  mf;
   wire  [1:0]  units;
   int          n_errors = 0;
   int          cmp_count = 0;
   // mapped, reserved and unmapped places with their writable masks
   logic [15:0] amap [11] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0006, 16'h0007,
                              16'h0008, 16'h0009, 16'h000a, 16'h000f, 16'h0010};
   logic [15:0] amask [11] = '{16'h0000, 16'h07ff, 16'hffff, 16'h0000, 16'hffff, 16'hffff,
                               16'hffff, 16'h00c3, 16'h0000, 16'h7002, 16'h0000};
   logic [15:0] aval [5] = '{16'h02d7, 16'h02d6, 16'h0294, 16'hfc18, 16'h7fff};
   logic [15:0] aexp [5] = '{16'h02d6, 16'h02d6, 16'h0294, 16'hfd2a, 16'h02d6};

   drb_top drb_top_inst (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr),
      .wr_data_i(wr_data), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .wr_ignored_o(wr_ign),
      .display_unit_param_i(unit_param), .drive_fault_relay_i(relay_in),
      .local_terminal_five_i(loc_in[0]), .local_terminal_six_i(loc_in[1]),
      .local_terminal_seven_i(loc_in[2]), .bcast_terminal_five_i(bc_in[0]),
      .bcast_terminal_six_i(bc_in[1]), .bcast_terminal_seven_i(bc_in[2]),
      .run_forward_o(fwd), .run_reverse_o(rev), .bus_external_fault_o(efault),
      .fault_reset_o(frst), .network_select_bit_o(nsel), .remote_control_bit_o(rctl),
      .mf_input_cmd_o(mf), .frequency_ref_o(freq), .frequency_units_o(units),
      .process_setpoint_o(setp), .process_setpoint_en_o(sp_en), .analog_out_one_o(ao1),
      .analog_out_two_o(ao2), .digital_out_one_terminal_o(d1), .digital_out_two_terminal_o(d2),
      .fault_relay_terminal_o(relay), .input_terminal_five_o(t5), .input_terminal_six_o(t6),
      .input_terminal_seven_o(t7));
   drb_master drb_master_inst (.clk_i(clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
      .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr), .wr_data_o(wr_data));

   task automatic chk_out(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_rd(input logic [15:0] a, input logic [15:0] e);
      drb_master_inst.read_reg(a, got, vld);
      chk_out("rd_valid_o", 16'h0001, {15'h0000, vld});
      chk_out("rd_data_o", e, got);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // whole sequence needs some 230 cycles, so this only cuts a hang
   initial begin
      #100us;
      n_errors++;
      final_report;
   end
   initial begin
      rst_n_i = 1'b0;
      unit_param = 2'h2;
      relay_in = 1'b1;
      loc_in = 3'h5;
      bc_in = 3'h2;
      repeat (20) @(negedge clk_i);
      rst_n_i = 1'b1;
      foreach (amap[i]) chk_rd(amap[i], 16'h0000);
      foreach (amap[i]) begin
         drb_master_inst.write_reg(amap[i], 16'hffff);
         chk_out("wr_ignored_o", {15'h0000, amask[i] == 16'h0000}, {15'h0000, wr_ign});
         chk_rd(amap[i], amask[i]);
      end
      $display("register map test done");
      for (int b = 0; b < 11; b++) begin
         drb_master_inst.write_reg(16'h0001, 16'h0001 << b);
         chk_out("fault_reset_o", {15'h0000, b == 3}, {15'h0000, frst});
         @(negedge clk_i);
         chk_out("sequence", (16'h0001 << b) & 16'h07f7,
                 {5'h00, mf, rctl, nsel, 1'b0, efault, rev, fwd});
      end
      drb_master_inst.write_pair(16'h0001, 32'h0001_0258);
      @(negedge clk_i);
      chk_out("frequency_ref_o", 16'h0258, freq);
      chk_out("frequency_units_o", {14'h0000, unit_param}, {14'h0000, units});
      unit_param = 2'h1;
      @(negedge clk_i);
      chk_out("frequency_units_o", 16'h0001, {14'h0000, units});
      $display("sequence test done");
      foreach (aval[i]) begin
         drb_master_inst.write_pair(16'h0007, {aval[i], -aval[i]});
         @(negedge clk_i);
         chk_out("analog_out_one_o", aexp[i], ao1);
         chk_out("analog_out_two_o", -aexp[i], ao2);
         chk_rd(16'h0008, -aexp[i]);
      end
      $display("analog test done");
      for (int k = 0; k < 8; k++) begin
         relay_in = k[2];
         drb_master_inst.write_reg(16'h0009, {8'h00, k[1], k[0], 4'h0, k[0], k[1]});
         @(negedge clk_i);
         chk_out("contacts", {13'h0000, k[0] ? k[1] : k[2], k[0], k[1]},
                 {13'h0000, relay, d2, d1});
      end
      drb_master_inst.write_reg(16'h0006, 16'h1234);
      for (int k = 0; k < 16; k++) begin
         drb_master_inst.write_reg(16'h000f, {1'b0, k[3:1], 10'h000, k[0], 1'b0});
         @(negedge clk_i);
         chk_out("selection", {12'h000, k[0], (k[3:1] & bc_in) | (~k[3:1] & loc_in)},
                 {12'h000, sp_en, t7, t6, t5});
      end
      chk_out("process_setpoint_o", 16'h1234, setp);
      $display("contact and selection test done");
      final_report;
   end
endmodule // tb_drb_top
